// file: logic/tls_pkg.sv
`default_nettype none
package tls_pkg;
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned SETTLE_TIME_MS = 1000;
   localparam int unsigned STALL_TIME_MS  = 3000;
   localparam int unsigned TLS_SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_TIME_MS;
   localparam int unsigned TLS_STALL_CYCLES  = CLK_HZ / 1000 * STALL_TIME_MS;
   localparam int unsigned TLS_N_INPUTS      = 12;

   // Limits are in 0.1 % steps, speeds and frequencies in 0.01 Hz steps.
   localparam logic [15:0] TLS_SENTINEL      = 16'h270F;
   localparam logic [15:0] TLS_LIM_MAX       = 16'h0FA0;
   localparam logic [15:0] TLS_SLV_FLOOR     = 16'h012C;
   localparam logic [15:0] TLS_BASE_INIT_STD = 16'h05DC;
   localparam logic [15:0] TLS_BASE_INIT_VEC = 16'h07D0;
   localparam logic [15:0] TLS_STALL_INIT    = 16'h05DC;
   localparam logic [15:0] TLS_COMM_OFFSET   = 16'h03E8;
   localparam logic [15:0] TLS_SETTLE_BAND   = 16'h00C8;
   localparam logic [15:0] TLS_A4_TORQUE     = 16'h0004;
   localparam logic [7:0]  TLS_FUNC_SECOND   = 8'h1B;
   localparam logic [31:0] TLS_PM_LOW_RATIO  = 32'h0000000A;
   localparam logic [15:0] TLS_OFS_SCALE     = 16'h000A;

   localparam logic [1:0] TLS_SRC_PARAM  = 2'h0;
   localparam logic [1:0] TLS_SRC_ANALOG = 2'h1;
   localparam logic [1:0] TLS_SRC_COMM   = 2'h2;

   localparam logic [3:0] TLS_ENC_OFS_RAM = 4'h1;
   localparam logic [3:0] TLS_ENC_OFS_BUS = 4'h3;
   localparam logic [3:0] TLS_ENC_TC_BUS  = 4'h5;
   localparam logic [3:0] TLS_ENC_TC_RAM  = 4'h6;

   localparam logic [2:0] TLS_CM_VF    = 3'h0;
   localparam logic [2:0] TLS_CM_AMFV  = 3'h1;
   localparam logic [2:0] TLS_CM_SLV   = 3'h2;
   localparam logic [2:0] TLS_CM_VEC   = 3'h3;
   localparam logic [2:0] TLS_CM_PMSLV = 3'h4;

   localparam logic [1:0] TLS_Q1 = 2'h0;
   localparam logic [1:0] TLS_Q2 = 2'h1;
   localparam logic [1:0] TLS_Q3 = 2'h2;
   localparam logic [1:0] TLS_Q4 = 2'h3;

   typedef enum logic [2:0] {
      TLS_CONST = 3'b001,
      TLS_ACCEL = 3'b010,
      TLS_DECEL = 3'b100
   } tls_motion_t;

   typedef struct packed {
      logic [15:0] base_limit_level;
      logic [15:0] regen_quadrant_limit;
      logic [15:0] third_quadrant_limit;
      logic [15:0] fourth_quadrant_limit;
      logic [15:0] second_limit_level;
      logic [15:0] accel_limit_level;
      logic [15:0] decel_limit_level;
      logic [15:0] stall_shutoff_level;
      logic [15:0] low_speed_threshold;
      logic [15:0] analog4_function_assign;
      logic [1:0]  limit_source_select;
      logic [3:0]  comm_limit_encoding_select;
      logic [2:0]  ctrl_method;
      logic        pos_ctrl;
      logic        torque_ctrl;
      logic        small_rating;
   } tls_settings_t;

   typedef struct packed {
      logic [15:0] set_speed;
      logic [15:0] act_speed;
      logic [15:0] torque;
      logic [15:0] rated_freq;
      logic [15:0] analog4_limit;
   } tls_drive_t;

   typedef struct packed {
      logic [15:0] torque_limit;
      logic        limit_enable;
      logic        limit_active;
      logic [1:0]  quadrant;
      tls_motion_t motion;
      logic        stall_trip_fault;
      logic [15:0] base_default;
   } tls_status_t;

   typedef struct packed {
      tls_status_t st;
      logic [15:0] comm_word;
      logic        was_vector;
   } tls_state_t;

   localparam tls_state_t TLS_STATE_RST = '{
      st: '{torque_limit: TLS_BASE_INIT_STD, limit_enable: 1'b0, limit_active: 1'b0,
            quadrant: TLS_Q1, motion: TLS_CONST, stall_trip_fault: 1'b0,
            base_default: TLS_BASE_INIT_STD},
      comm_word: TLS_COMM_OFFSET,
      was_vector: 1'b0
   };
endpackage
`default_nettype wire

// file: logic/tls_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Raises done after cond has held for CYCLES consecutive clocks.
module tls_hold_timer import tls_pkg::*; #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic cond_i,
   output var  logic done_o
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] count;
      logic         done;
   } tls_hold_t;

   tls_hold_t hold_reg;
   tls_hold_t hold_next;

   always_comb begin
      hold_next = hold_reg;
      if (!cond_i) begin
         hold_next = '0;
      end else if (!hold_reg.done) begin
         hold_next.done  = (hold_reg.count == LAST);
         hold_next.count = hold_reg.count + W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_reg <= '0;
      end else begin
         hold_reg <= hold_next;
      end
   end

   assign done_o = hold_reg.done;

   property p_hold_done;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(hold_reg.done) |-> $past(cond_i) && ($past(hold_reg.count) == LAST);
   endproperty
   a_hold_done: assert property (p_hold_done) else $error("hold timer finished early");
endmodule // tls_hold_timer
`default_nettype wire

// file: logic/tls_torque_limit_selector.sv
`timescale 1ns/1ps
`default_nettype none
module tls_torque_limit_selector import tls_pkg::*; #(
   parameter int unsigned SETTLE_CYCLES = TLS_SETTLE_CYCLES,
   parameter int unsigned STALL_CYCLES  = TLS_STALL_CYCLES,
   parameter int unsigned N_INPUTS      = TLS_N_INPUTS
) (
   input  wire logic                      REF_CLK_I,
   input  wire logic                      NRST_I,
   input  wire tls_settings_t             SETTINGS_I,
   input  wire logic [N_INPUTS-1:0][7:0]  INPUT_FUNCTION_SELECTS_I,
   input  wire logic [N_INPUTS-1:0]       INPUT_TERMINALS_I,
   input  wire tls_drive_t                DRIVE_I,
   input  wire logic                      COMM_WR_I,
   input  wire logic [15:0]               COMM_WR_DATA_I,
   input  wire logic                      FIELDBUS_WR_I,
   input  wire logic [15:0]               FIELDBUS_LIMIT_WORD_I,
   input  wire logic                      FAULT_CLR_I,
   output var  tls_status_t               STATUS_O
);
   tls_state_t         state_reg;
   tls_state_t         state_next;
   logic [N_INPUTS-1:0] tl_hit;
   logic               tl_sel;
   logic [1:0]         quad;
   logic [15:0]        internal_lim;
   logic [15:0]        src_lim;
   logic [15:0]        const_lim;
   logic [15:0]        ad_lim;
   logic [15:0]        floor_lim;
   logic [15:0]        eff_lim;
   logic [15:0]        comm_mag;
   logic [15:0]        trq_abs;
   logic [15:0]        spd_abs;
   logic [15:0]        tc_abs;
   logic [16:0]        ofs_abs;
   logic [19:0]        ofs_mag;
   logic signed [16:0] ofs_diff;
   logic signed [16:0] spd_err;
   logic [31:0]        scaled;
   logic               enc_ofs;
   logic               enc_tc;
   logic               bus_enc;
   logic               analog_ok;
   logic               accel_req;
   logic               decel_req;
   logic               in_band;
   logic               settle_done;
   logic               stall_cond;
   logic               stall_done;
   logic               is_slv;
   logic               is_pm;
   logic               pm_low;
   logic               pm_const_pow;
   logic               limit_en;
   logic               limit_act;
   logic               vector_cm;

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!NRST_I);

   function automatic logic [15:0] pick_level(input logic [15:0] setting, input logic [15:0] fallback);
      pick_level = (setting == TLS_SENTINEL) ? fallback : setting;
   endfunction

   function automatic logic [15:0] mag16(input logic [15:0] v);
      mag16 = v[15] ? 16'(~v + 16'h0001) : v;
   endfunction

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      min16 = (a < b) ? a : b;
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < N_INPUTS; gi++) begin : g_tl
         assign tl_hit[gi] = INPUT_TERMINALS_I[gi] && (INPUT_FUNCTION_SELECTS_I[gi] == TLS_FUNC_SECOND);
      end
   endgenerate
   assign tl_sel = |tl_hit;

   // Quadrant code is {speed negative, speed and torque of opposite sign}.
   assign quad    = {DRIVE_I.act_speed[15], DRIVE_I.act_speed[15] ^ DRIVE_I.torque[15]};
   assign trq_abs = mag16(DRIVE_I.torque);
   assign spd_abs = mag16(DRIVE_I.act_speed);

   always_comb begin
      case (quad)
         TLS_Q2: begin
            internal_lim = pick_level(SETTINGS_I.regen_quadrant_limit, SETTINGS_I.base_limit_level);
         end
         TLS_Q3: begin
            internal_lim = pick_level(SETTINGS_I.third_quadrant_limit, SETTINGS_I.base_limit_level);
         end
         TLS_Q4: begin
            internal_lim = pick_level(SETTINGS_I.fourth_quadrant_limit, SETTINGS_I.base_limit_level);
         end
         default: begin
            internal_lim = SETTINGS_I.base_limit_level;
         end
      endcase
   end

   // Communication word decode; both forms clamp to the 400 % ceiling.
   assign enc_ofs  = (SETTINGS_I.comm_limit_encoding_select == TLS_ENC_OFS_RAM)
                  || (SETTINGS_I.comm_limit_encoding_select == TLS_ENC_OFS_BUS);
   assign enc_tc   = (SETTINGS_I.comm_limit_encoding_select == TLS_ENC_TC_BUS)
                  || (SETTINGS_I.comm_limit_encoding_select == TLS_ENC_TC_RAM);
   assign bus_enc  = (SETTINGS_I.comm_limit_encoding_select == TLS_ENC_OFS_BUS)
                  || (SETTINGS_I.comm_limit_encoding_select == TLS_ENC_TC_BUS);
   assign ofs_diff = $signed({1'b0, state_reg.comm_word}) - $signed({1'b0, TLS_COMM_OFFSET});
   assign ofs_abs  = ofs_diff[16] ? 17'(-ofs_diff) : 17'(ofs_diff);
   assign ofs_mag  = {ofs_abs, 3'b000} + 20'({ofs_abs, 1'b0});
   assign tc_abs   = mag16(state_reg.comm_word) / TLS_OFS_SCALE;

   always_comb begin
      if (enc_ofs) begin
         comm_mag = (ofs_mag > 20'(TLS_LIM_MAX)) ? TLS_LIM_MAX : 16'(ofs_mag);
      end else begin
         comm_mag = min16(tc_abs, TLS_LIM_MAX);
      end
   end

   assign analog_ok = (SETTINGS_I.analog4_function_assign == TLS_A4_TORQUE);

   always_comb begin
      case (SETTINGS_I.limit_source_select)
         TLS_SRC_ANALOG: begin
            src_lim = analog_ok ? min16(DRIVE_I.analog4_limit, internal_lim) : internal_lim;
         end
         TLS_SRC_COMM: begin
            src_lim = (enc_ofs || enc_tc) ? comm_mag : internal_lim;
         end
         default: begin
            src_lim = internal_lim;
         end
      endcase
   end

   assign const_lim = tl_sel ? pick_level(SETTINGS_I.second_limit_level, src_lim) : src_lim;

   // Speed error decides the motion state; the band edge counts as outside.
   assign spd_err   = $signed({DRIVE_I.set_speed[15], DRIVE_I.set_speed})
                    - $signed({DRIVE_I.act_speed[15], DRIVE_I.act_speed});
   assign accel_req = spd_err >= $signed({1'b0, TLS_SETTLE_BAND});
   assign decel_req = spd_err <= -$signed({1'b0, TLS_SETTLE_BAND});
   assign in_band   = !accel_req && !decel_req;

   tls_hold_timer #(
      .CYCLES (SETTLE_CYCLES)
   ) u_settle (
      .clk_i   (REF_CLK_I),
      .rst_n_i (NRST_I),
      .cond_i  (in_band),
      .done_o  (settle_done)
   );

   always_comb begin
      if (SETTINGS_I.pos_ctrl) begin
         ad_lim = const_lim;
      end else begin
         case (state_reg.st.motion)
            TLS_ACCEL: begin
               ad_lim = pick_level(SETTINGS_I.accel_limit_level, const_lim);
            end
            TLS_DECEL: begin
               ad_lim = pick_level(SETTINGS_I.decel_limit_level, const_lim);
            end
            default: begin
               ad_lim = const_lim;
            end
         endcase
      end
   end

   assign is_slv       = (SETTINGS_I.ctrl_method == TLS_CM_SLV);
   assign is_pm        = (SETTINGS_I.ctrl_method == TLS_CM_PMSLV);
   assign floor_lim    = (is_slv && ad_lim < TLS_SLV_FLOOR) ? TLS_SLV_FLOOR : ad_lim;
   assign pm_low       = is_pm && (32'(spd_abs) * TLS_PM_LOW_RATIO < 32'(DRIVE_I.rated_freq));
   assign pm_const_pow = is_pm && (DRIVE_I.rated_freq != 16'h0000) && (spd_abs >= DRIVE_I.rated_freq);
   // The divisor is forced to one outside the constant-power range to avoid a zero divide.
   assign scaled       = (32'(floor_lim) * 32'(DRIVE_I.rated_freq)) / 32'(pm_const_pow ? spd_abs : 16'h0001);
   assign eff_lim      = pm_const_pow ? scaled[15:0] : floor_lim;
   assign limit_en     = !pm_low;
   assign limit_act    = limit_en && (trq_abs >= eff_lim);

   assign stall_cond = !SETTINGS_I.torque_ctrl && limit_act
                    && (spd_abs < SETTINGS_I.low_speed_threshold)
                    && (trq_abs > SETTINGS_I.stall_shutoff_level);

   tls_hold_timer #(
      .CYCLES (STALL_CYCLES)
   ) u_stall (
      .clk_i   (REF_CLK_I),
      .rst_n_i (NRST_I),
      .cond_i  (stall_cond),
      .done_o  (stall_done)
   );

   assign vector_cm = is_slv || (SETTINGS_I.ctrl_method == TLS_CM_VEC);

   always_comb begin
      state_next                 = state_reg;
      state_next.st.torque_limit = eff_lim;
      state_next.st.limit_enable = limit_en;
      state_next.st.limit_active = limit_act;
      state_next.st.quadrant     = quad;
      if (accel_req) begin
         state_next.st.motion = TLS_ACCEL;
      end else if (decel_req) begin
         state_next.st.motion = TLS_DECEL;
      end else if (settle_done) begin
         state_next.st.motion = TLS_CONST;
      end
      if (stall_done) begin
         state_next.st.stall_trip_fault = 1'b1;
      end else if (FAULT_CLR_I) begin
         state_next.st.stall_trip_fault = 1'b0;
      end
      if (FIELDBUS_WR_I && bus_enc) begin
         state_next.comm_word = FIELDBUS_LIMIT_WORD_I;
      end else if (COMM_WR_I) begin
         state_next.comm_word = COMM_WR_DATA_I;
      end
      state_next.was_vector = vector_cm;
      if (SETTINGS_I.small_rating && vector_cm && !state_reg.was_vector) begin
         state_next.st.base_default = TLS_BASE_INIT_VEC;
      end else if (!vector_cm && state_reg.was_vector) begin
         state_next.st.base_default = TLS_BASE_INIT_STD;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_reg <= TLS_STATE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign STATUS_O = state_reg.st;

   sequence s_settled;
      settle_done ##0 in_band;
   endsequence

   sequence s_stall_end;
      stall_done ##0 FAULT_CLR_I;
   endsequence

   property p_accel;
      (state_reg.st.motion == TLS_ACCEL) && !SETTINGS_I.pos_ctrl && (SETTINGS_I.accel_limit_level != TLS_SENTINEL)
      |-> ad_lim == SETTINGS_I.accel_limit_level;
   endproperty
   a_accel: assert property (p_accel) else $error("acceleration limit not applied");

   property p_decel;
      (state_reg.st.motion == TLS_DECEL) && !SETTINGS_I.pos_ctrl && (SETTINGS_I.decel_limit_level == TLS_SENTINEL)
      |-> ad_lim == const_lim;
   endproperty
   a_decel: assert property (p_decel) else $error("deceleration fallback wrong");

   property p_quad_fallback;
      (quad == TLS_Q2) && (SETTINGS_I.regen_quadrant_limit == TLS_SENTINEL)
      |-> internal_lim == SETTINGS_I.base_limit_level;
   endproperty
   a_quad_fallback: assert property (p_quad_fallback) else $error("quadrant fallback wrong");

   property p_analog_min;
      (SETTINGS_I.limit_source_select == TLS_SRC_ANALOG)
      |-> (src_lim <= internal_lim) && (analog_ok || src_lim == internal_lim);
   endproperty
   a_analog_min: assert property (p_analog_min) else $error("analog limit above internal");

   property p_second;
      tl_sel && (SETTINGS_I.second_limit_level != TLS_SENTINEL)
      |-> const_lim == SETTINGS_I.second_limit_level;
   endproperty
   a_second: assert property (p_second) else $error("second limit not forced");

   property p_offset_zero;
      enc_ofs && (state_reg.comm_word == TLS_COMM_OFFSET) |-> comm_mag == 16'h0000;
   endproperty
   a_offset_zero: assert property (p_offset_zero) else $error("offset decode wrong");

   property p_twos;
      enc_tc && (state_reg.comm_word == 16'hCFC7) |-> comm_mag == 16'h04D2;
   endproperty
   a_twos: assert property (p_twos) else $error("signed decode wrong");

   property p_slv_floor;
      is_slv |=> STATUS_O.torque_limit >= TLS_SLV_FLOOR;
   endproperty
   a_slv_floor: assert property (p_slv_floor) else $error("floor not kept");

   property p_pm_low;
      pm_low |=> !STATUS_O.limit_enable && !STATUS_O.limit_active;
   endproperty
   a_pm_low: assert property (p_pm_low) else $error("limit active at low PM speed");

   property p_stall_trip;
      s_stall_end or stall_done |=> STATUS_O.stall_trip_fault;
   endproperty
   a_stall_trip: assert property (p_stall_trip) else $error("stall trip lost");

   property p_settle;
      s_settled |=> STATUS_O.motion == TLS_CONST;
   endproperty
   a_settle: assert property (p_settle) else $error("constant limit not restored");

   property p_base_default;
      SETTINGS_I.small_rating && vector_cm && !state_reg.was_vector |=> STATUS_O.base_default == TLS_BASE_INIT_VEC;
   endproperty
   a_base_default: assert property (p_base_default) else $error("base default not raised");
endmodule // tls_torque_limit_selector
`default_nettype wire

// file: bench/tls_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the speed loop. The command passes through one register; in slow mode the actual
// speed ramps towards the set speed, so the selector sees a real speed error that shrinks over time.
module tls_drive_model import tls_pkg::*; (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire tls_drive_t cmd_i,
   input  wire logic       slow_i,
   output var  tls_drive_t drive_o
);
   int gap;
   always_comb gap = int'($signed(cmd_i.set_speed)) - int'($signed(drive_o.act_speed));
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drive_o <= '0;
      end else begin
         drive_o <= cmd_i;
         if (slow_i) begin
            if (gap > 50) drive_o.act_speed <= drive_o.act_speed + 16'h0032;
            else if (gap < -50) drive_o.act_speed <= drive_o.act_speed - 16'h0032;
            else drive_o.act_speed <= cmd_i.set_speed;
         end
      end
   end
endmodule // tls_drive_model
`default_nettype wire

// file: bench/torque_limit_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module torque_limit_selector_tb import tls_pkg::*; ;
   localparam logic [15:0] NA = TLS_SENTINEL;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   tls_settings_t cfg;
   tls_drive_t cmd, drv;
   tls_status_t st;
   logic [11:0][7:0] fsel, f;
   logic [11:0] term;
   logic slow, cwr, fwr, fclr;
   logic [15:0] cdat, fdat, e, sw;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int k, q;
   int encs [7] = '{1, 1, 3, 6, 6, 5, 6};
   logic [15:0] wds [7] = '{16'h044C, 16'h0384, 16'h0578, 16'hCFC7, 16'h2710, 16'hF060, 16'h04B0};
   bit bus [7] = '{0, 0, 1, 0, 0, 1, 1};

   always #4 ref_clk = ~ref_clk;

   tls_torque_limit_selector #(.SETTLE_CYCLES(20), .STALL_CYCLES(40), .N_INPUTS(12)) dut_u (
      .REF_CLK_I(ref_clk), .NRST_I(nrst), .SETTINGS_I(cfg), .INPUT_FUNCTION_SELECTS_I(fsel),
      .INPUT_TERMINALS_I(term), .DRIVE_I(drv), .COMM_WR_I(cwr), .COMM_WR_DATA_I(cdat),
      .FIELDBUS_WR_I(fwr), .FIELDBUS_LIMIT_WORD_I(fdat), .FAULT_CLR_I(fclr), .STATUS_O(st));
   tls_drive_model model_u (.clk_i(ref_clk), .rst_n_i(nrst), .cmd_i(cmd), .slow_i(slow), .drive_o(drv));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic done_test(input string name);
      $display("test %s done, mismatches so far %0d", name, errors);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Speed equals set speed so the motion state never leaves constant speed.
   task automatic dv(input logic [15:0] sp, input logic [15:0] tq);
      @(posedge ref_clk);
      cmd.set_speed <= sp;
      cmd.act_speed <= sp;
      cmd.torque <= tq;
      wt(3);
   endtask
   task automatic cw(input bit b, input logic [15:0] w);
      @(posedge ref_clk);
      if (b) begin
         fwr <= 1'b1;
         fdat <= w;
      end else begin
         cwr <= 1'b1;
         cdat <= w;
      end
      @(posedge ref_clk);
      cwr <= 1'b0;
      fwr <= 1'b0;
      wt(2);
   endtask

   function automatic logic [15:0] dec(input int enc, input logic [15:0] w);
      int v;
      if (enc == 1 || enc == 3) v = (int'(w) - 1000) * 10;
      else v = int'($signed(w)) / 10;
      if (v < 0) v = -v;
      if (v > 4000) v = 4000;
      return v[15:0];
   endfunction
   function automatic logic [15:0] qexp(input int qd, input logic sel);
      logic [15:0] r;
      r = cfg.base_limit_level;
      if (qd == 1 && cfg.regen_quadrant_limit != NA) r = cfg.regen_quadrant_limit;
      if (qd == 2 && cfg.third_quadrant_limit != NA) r = cfg.third_quadrant_limit;
      if (qd == 3 && cfg.fourth_quadrant_limit != NA) r = cfg.fourth_quadrant_limit;
      if (sel && cfg.second_limit_level != NA) r = cfg.second_limit_level;
      return r;
   endfunction
   function automatic logic [15:0] rlim();
      return ($urandom_range(3) == 0) ? NA : 16'($urandom_range(4000));
   endfunction

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         $display("CHECK FAILED run time expected %0d seen %0d", 20000, cyc);
         report_and_stop();
      end
   end

   initial begin
      cfg = '0;
      cfg.base_limit_level = 16'h03E8;
      cfg.regen_quadrant_limit = NA;
      cfg.third_quadrant_limit = NA;
      cfg.fourth_quadrant_limit = NA;
      cfg.second_limit_level = NA;
      cfg.accel_limit_level = NA;
      cfg.decel_limit_level = NA;
      cfg.stall_shutoff_level = TLS_STALL_INIT;
      cfg.comm_limit_encoding_select = TLS_ENC_OFS_RAM;
      {fsel, term, cmd, slow, cwr, fwr, fclr, cdat, fdat} = '0;
      void'($urandom(32'h9BA4));
      wt(3);
      chk("reset limit", TLS_BASE_INIT_STD, st.torque_limit);
      chk("reset base default", TLS_BASE_INIT_STD, st.base_default);
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      wt(2);
      done_test("reset");
      for (int i = 0; i < 24; i++) begin
         @(posedge ref_clk);
         cfg.base_limit_level <= 16'($urandom_range(4000));
         cfg.regen_quadrant_limit <= rlim();
         cfg.third_quadrant_limit <= rlim();
         cfg.fourth_quadrant_limit <= rlim();
         cfg.second_limit_level <= rlim();
         k = $urandom_range(11);
         f = '0;
         f[k] = ($urandom_range(1) == 1) ? TLS_FUNC_SECOND : 8'h1A;
         fsel <= f;
         term <= 12'($urandom_range(4095));
         q = $urandom_range(3);
         dv((q < 2) ? 16'h03E8 : 16'hFC18, (q == 0 || q == 3) ? 16'h0064 : 16'hFF9C);
         chk("quadrant", 16'(q), {14'h0, st.quadrant});
         e = qexp(q, fsel[k] == TLS_FUNC_SECOND && term[k]);
         chk("quadrant limit", e, st.torque_limit);
         chk("limit active", {15'h0, e <= 16'h0064}, {15'h0, st.limit_active});
      end
      done_test("quadrant and second limit");
      @(posedge ref_clk);
      term <= '0;
      cfg.limit_source_select <= TLS_SRC_ANALOG;
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         cmd.analog4_limit <= 16'($urandom_range(4000));
         cfg.analog4_function_assign <= (i % 2 == 1) ? 16'h0006 : TLS_A4_TORQUE;
         dv(16'h03E8, 16'h0064);
         e = cfg.base_limit_level;
         if (i % 2 == 0 && cmd.analog4_limit < e) e = cmd.analog4_limit;
         chk("analog limit", e, st.torque_limit);
      end
      done_test("analog");
      @(posedge ref_clk);
      cfg.limit_source_select <= TLS_SRC_COMM;
      sw = TLS_COMM_OFFSET;
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         cfg.comm_limit_encoding_select <= 4'(encs[i]);
         cw(bus[i], wds[i]);
         if (!bus[i] || encs[i] == 3 || encs[i] == 5) sw = wds[i];
         chk("comm limit", dec(encs[i], sw), st.torque_limit);
      end
      done_test("communication");
      @(posedge ref_clk);
      cfg.limit_source_select <= TLS_SRC_PARAM;
      cfg.regen_quadrant_limit <= NA;
      cfg.second_limit_level <= NA;
      cfg.base_limit_level <= 16'h03E8;
      cfg.accel_limit_level <= 16'h09C4;
      cfg.decel_limit_level <= 16'h01F4;
      slow <= 1'b1;
      cmd.torque <= 16'h0000;
      cmd.set_speed <= 16'h0BB8;
      wt(8);
      chk("accel motion", {13'h0, TLS_ACCEL}, {13'h0, st.motion});
      chk("accel limit", 16'h09C4, st.torque_limit);
      @(posedge ref_clk);
      cfg.pos_ctrl <= 1'b1;
      wt(2);
      chk("position control limit", 16'h03E8, st.torque_limit);
      @(posedge ref_clk);
      cfg.pos_ctrl <= 1'b0;
      @(posedge ref_clk);
      cfg.accel_limit_level <= NA;
      wt(3);
      chk("accel fallback", 16'h03E8, st.torque_limit);
      wt(70);
      chk("settled motion", {13'h0, TLS_CONST}, {13'h0, st.motion});
      @(posedge ref_clk);
      cmd.set_speed <= 16'h03E8;
      wt(8);
      chk("decel limit", 16'h01F4, st.torque_limit);
      @(posedge ref_clk);
      cfg.decel_limit_level <= NA;
      wt(3);
      chk("decel fallback", 16'h03E8, st.torque_limit);
      @(posedge ref_clk);
      cfg.decel_limit_level <= 16'h01F4;
      wt(69);
      chk("settled limit", 16'h03E8, st.torque_limit);
      done_test("motion");
      @(posedge ref_clk);
      slow <= 1'b0;
      cfg.ctrl_method <= TLS_CM_SLV;
      cfg.base_limit_level <= 16'h0064;
      wt(3);
      chk("sensorless floor", TLS_SLV_FLOOR, st.torque_limit);
      @(posedge ref_clk);
      cfg.ctrl_method <= TLS_CM_PMSLV;
      cfg.base_limit_level <= 16'h03E8;
      cmd.rated_freq <= 16'h1388;
      dv(16'h0190, 16'h0000);
      chk("pm low speed enable", 16'h0000, {15'h0, st.limit_enable});
      dv(16'h01F4, 16'h0000);
      chk("pm edge enable", 16'h0001, {15'h0, st.limit_enable});
      dv(16'h2710, 16'h0000);
      chk("pm scaled limit", 16'h01F4, st.torque_limit);
      done_test("control method clamps");
      @(posedge ref_clk);
      cfg.ctrl_method <= TLS_CM_VF;
      cfg.small_rating <= 1'b1;
      wt(2);
      @(posedge ref_clk);
      cfg.ctrl_method <= TLS_CM_VEC;
      wt(3);
      chk("vector base default", TLS_BASE_INIT_VEC, st.base_default);
      @(posedge ref_clk);
      cfg.ctrl_method <= TLS_CM_VF;
      cfg.low_speed_threshold <= 16'h01F4;
      wt(3);
      chk("scalar base default", TLS_BASE_INIT_STD, st.base_default);
      dv(16'h0064, 16'h07D0);
      wt(30);
      chk("stall early", 16'h0000, {15'h0, st.stall_trip_fault});
      chk("stall limit active", 16'h0001, {15'h0, st.limit_active});
      wt(15);
      chk("stall trip", 16'h0001, {15'h0, st.stall_trip_fault});
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         cfg.stall_shutoff_level <= (i == 0) ? 16'h07D0 : 16'h07CF;
         cfg.torque_ctrl <= (i == 2);
         @(posedge ref_clk);
         fclr <= 1'b1;
         @(posedge ref_clk);
         fclr <= 1'b0;
         wt(2);
         chk("fault clear", 16'h0000, {15'h0, st.stall_trip_fault});
         wt(50);
         chk("stall level", 16'(i == 1), {15'h0, st.stall_trip_fault});
      end
      done_test("stall");
      report_and_stop();
   end
endmodule // torque_limit_selector_tb
`default_nettype wire
